// ===== rtl/rsw_top.sv
// Register bank, self-polling sequencer and front-end settle timer.
// Assumes the serial framing logic presents one-cycle read/write strobes.
`timescale 1ns/1ps
module rsw_top #(
	parameter int STEP_CYC = rsw_pkg::STEP_CYCLES, // Cycles per 0.08 ms
	parameter logic [7:0] PART_CODE = 8'h5A // Arbitrary designator value
) (
	input wire logic i_clk, // 100 MHz clock
	input wire logic i_rst_b, // Async reset, active low
	input wire logic i_wr, // Register write strobe
	input wire logic i_rd, // Register read strobe
	input wire logic [7:0] i_addr, // Register address
	input wire logic [7:0] i_wdata, // Write data
	input wire logic i_preamble_found, // Preamble detector pulse
	output logic [7:0] o_rdata, // Read data, registered
	output logic o_rvalid, // Read data valid pulse
	output logic o_front_end_on, // Receiver front end settled
	output logic o_rx_active, // Receiver powered
	output logic [1:0] o_rx_state, // Receiver state code
	output logic o_osc_enable, // Oscillator enable
	output logic o_dig_ready, // Digital clock applied
	output logic o_dig_tick, // Divided digital clock tick
	output logic o_lo_injection_side, // 1: RF below LO
	output logic [1:0] o_lo_band_divider, // 0 disables the PLL
	output logic o_pll_fractional_select, // PLL mode
	output logic [4:0] o_image_rejection_trim // Image rejection trim
);
	import rsw_pkg::*;

	// Elaboration check: the prescaler and step counter are sixteen bits
	if (STEP_CYC < 1 || STEP_CYC > 65535) begin : g_bad_step
		$error("STEP_CYC out of range");
	end

	typedef struct packed {
		logic [2:0] control;
		logic preamble_found_flag;
		logic [1:0] settle;
		logic [7:0] poll_listen_duration;
		logic [6:0] sleep_to_listen_ratio;
		logic [7:0] afe;
		logic [4:0] trim;
		rsw_state_e state;
		logic [15:0] pre_cnt;
		logic [15:0] step_cnt;
		logic [2:0] settle_cnt;
		logic fe_on;
		logic [7:0] rdata;
		logic rvalid;
	} rsw_top_s;

	rsw_top_s cur_ff;
	rsw_top_s nxt_cur;
	logic step;
	logic [8:0] listen_steps;
	logic [15:0] wait_steps;
	logic [2:0] settle_steps;
	logic rx_on;

	////////////////////////////////////////////////////////////////////////
	// Digital clock gate for the oscillator path
	rsw_xo_gate u_gate (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_osc_en(cur_ff.control[CTL_OSC]),
		.i_delay_code(cur_ff.afe[AFE_DLY_LSB +: 2]),
		.i_div_code(cur_ff.afe[AFE_DIV_LSB +: 2]),
		.o_ready(o_dig_ready),
		.o_dig_tick(o_dig_tick)
	);

	// Address decode shared by read and write paths
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction : hit

	////////////////////////////////////////////////////////////////////////
	// Durations in 0.08 ms steps
	always_comb begin
		listen_steps = LISTEN_BASE_STEPS
			+ {1'b0, cur_ff.poll_listen_duration};
		// Wait of (1+ratio) listens gives receive share 1/(2+ratio)
		wait_steps = 16'(({9'h000, cur_ff.sleep_to_listen_ratio} + 16'h0001)
			* {7'h00, listen_steps});
		settle_steps = {1'b0, cur_ff.settle} + 3'h1;
		rx_on = (cur_ff.state == ST_DIRECT) || (cur_ff.state == ST_POLL);
	end

	// Step counter only runs while the digital clock is applied
	assign step = o_dig_ready && (cur_ff.pre_cnt == 16'(STEP_CYC - 1));

	////////////////////////////////////////////////////////////////////////
	// Next-state logic: registers, sequencer, settle timer, read port
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.rvalid = 1'b0;
		// Prescaler to one step
		if (!o_dig_ready || step) begin
			nxt_cur.pre_cnt = 16'h0000;
		end else begin
			nxt_cur.pre_cnt = cur_ff.pre_cnt + 16'h0001;
		end
		// Register writes; read-only addresses fall through untouched
		if (i_wr) begin
			if (hit(i_addr, ADDR_CONTROL)) begin
				nxt_cur.control = i_wdata[2:0];
			end
			if (hit(i_addr, ADDR_SETTLE)) begin
				nxt_cur.settle = i_wdata[1:0];
			end
			if (hit(i_addr, ADDR_LISTEN)) begin
				nxt_cur.poll_listen_duration = i_wdata;
			end
			if (hit(i_addr, ADDR_RATIO)) begin
				nxt_cur.sleep_to_listen_ratio = i_wdata[6:0];
			end
			if (hit(i_addr, ADDR_AFE)) begin
				nxt_cur.afe = i_wdata;
			end
			if (hit(i_addr, ADDR_TRIM)) begin
				nxt_cur.trim = i_wdata[4:0];
			end
		end
		// Preamble flag clears on read; a new detection wins over the clear
		if (i_rd && hit(i_addr, ADDR_STATUS)) begin
			nxt_cur.preamble_found_flag = 1'b0;
		end
		if (i_preamble_found && cur_ff.state == ST_POLL) begin
			nxt_cur.preamble_found_flag = 1'b1;
		end
		// Receiver sequencer; direct receive outranks self-polling
		case (cur_ff.state)
			ST_STANDBY: begin
				nxt_cur.step_cnt = 16'h0000;
				if (cur_ff.control[CTL_OSC] && cur_ff.control[CTL_RX]) begin
					nxt_cur.state = ST_DIRECT;
				end else if (cur_ff.control[CTL_OSC] && cur_ff.control[CTL_WUT]) begin
					nxt_cur.state = ST_WAIT;
				end
			end
			ST_DIRECT: begin
				if (!cur_ff.control[CTL_OSC] || !cur_ff.control[CTL_RX]) begin
					nxt_cur.state = ST_STANDBY;
				end
			end
			ST_WAIT: begin
				if (!cur_ff.control[CTL_OSC] || !cur_ff.control[CTL_WUT]
					|| cur_ff.control[CTL_RX]) begin
					nxt_cur.state = ST_STANDBY;
				end else if (step) begin
					if (cur_ff.step_cnt + 16'h0001 >= wait_steps) begin
						nxt_cur.step_cnt = 16'h0000;
						nxt_cur.state = ST_POLL;
					end else begin
						nxt_cur.step_cnt = cur_ff.step_cnt + 16'h0001;
					end
				end
			end
			ST_POLL: begin
				if (!cur_ff.control[CTL_OSC] || !cur_ff.control[CTL_WUT]
					|| cur_ff.control[CTL_RX]) begin
					nxt_cur.state = ST_STANDBY;
				end else if (step) begin
					if (cur_ff.step_cnt + 16'h0001 >= {7'h00, listen_steps}) begin
						nxt_cur.step_cnt = 16'h0000;
						nxt_cur.state = ST_WAIT;
					end else begin
						nxt_cur.step_cnt = cur_ff.step_cnt + 16'h0001;
					end
				end
			end
			default: begin
				nxt_cur.state = ST_STANDBY;
			end
		endcase
		// Front end counts settle steps from each receiver turn-on
		if (!rx_on) begin
			nxt_cur.settle_cnt = 3'h0;
			nxt_cur.fe_on = 1'b0;
		end else if (step && !cur_ff.fe_on) begin
			if (cur_ff.settle_cnt + 3'h1 >= settle_steps) begin
				nxt_cur.fe_on = 1'b1;
			end else begin
				nxt_cur.settle_cnt = cur_ff.settle_cnt + 3'h1;
			end
		end
		// Read port; unmapped and reserved bits return zero
		if (i_rd) begin
			nxt_cur.rvalid = 1'b1;
			case (i_addr)
				ADDR_STATUS: nxt_cur.rdata = {7'h00, cur_ff.preamble_found_flag};
				ADDR_CONTROL: nxt_cur.rdata = {5'h00, cur_ff.control};
				ADDR_STATE: nxt_cur.rdata = {6'h00, o_rx_state};
				ADDR_SETTLE: nxt_cur.rdata = {6'h00, cur_ff.settle};
				ADDR_LISTEN: nxt_cur.rdata = cur_ff.poll_listen_duration;
				ADDR_RATIO: nxt_cur.rdata = {1'b0, cur_ff.sleep_to_listen_ratio};
				ADDR_AFE: nxt_cur.rdata = cur_ff.afe;
				ADDR_TRIM: nxt_cur.rdata = {3'h0, cur_ff.trim};
				// Designator needs the oscillator running
				ADDR_PART: nxt_cur.rdata = cur_ff.control[CTL_OSC] ? PART_CODE
					: 8'h00;
				default: nxt_cur.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cur_ff.control <= 3'h0;
			cur_ff.preamble_found_flag <= 1'b0;
			cur_ff.settle <= SETTLE_RST;
			cur_ff.poll_listen_duration <= LISTEN_RST;
			cur_ff.sleep_to_listen_ratio <= RATIO_RST;
			cur_ff.afe <= AFE_RST;
			cur_ff.trim <= TRIM_RST;
			cur_ff.state <= ST_STANDBY;
			cur_ff.pre_cnt <= 16'h0000;
			cur_ff.step_cnt <= 16'h0000;
			cur_ff.settle_cnt <= 3'h0;
			cur_ff.fe_on <= 1'b0;
			cur_ff.rdata <= 8'h00;
			cur_ff.rvalid <= 1'b0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	always_comb begin
		case (cur_ff.state)
			ST_DIRECT: o_rx_state = RXS_DIRECT;
			ST_WAIT: o_rx_state = RXS_WAIT;
			ST_POLL: o_rx_state = RXS_POLL;
			default: o_rx_state = RXS_STANDBY;
		endcase
	end
	assign o_rdata = cur_ff.rdata;
	assign o_rvalid = cur_ff.rvalid;
	assign o_front_end_on = cur_ff.fe_on;
	assign o_rx_active = rx_on;
	assign o_osc_enable = cur_ff.control[CTL_OSC];
	assign o_lo_injection_side = cur_ff.afe[AFE_INJ];
	assign o_lo_band_divider = cur_ff.afe[AFE_LO_LSB +: 2];
	// Host is trusted to keep this bit at one
	assign o_pll_fractional_select = cur_ff.afe[AFE_FRAC];
	assign o_image_rejection_trim = cur_ff.trim;
endmodule : rsw_top

// ===== rtl/rsw_pkg.sv
// Constants for the receiver state, wake-up timer and front-end config bank.
// Assumes a single 100 MHz clock standing in for the oscillator clock.
// Notes on behaviour
// - Read-only two-bit state: standby, direct receive, poll wait, poll receive.
// - Two-bit turn-on selector, reset 3, gives 0.08 to 0.32 ms settle.
// - Eight-bit listen field sets listen time 0.48 ms plus 0.08 ms steps.
// - Listen time ranges from 0.48 ms to 20.88 ms in 0.08 ms steps.
// - Oscillator clock reaches logic after none, 16, 32 or 64 cycles.
// - Digital clock divides oscillator by 4, 5 or 6; code 3 invalid.
// - Bit 3 selects RF above LO (0, default) or below LO (1).
// - Bits 2:1 disable the PLL at 0, else select one of three bands.
// - Five-bit image rejection trim, reset zero, drives receive path.
// - Part designator reads validly only once oscillator enable is set.
// - Control bits enable oscillator, wake-up timer and direct receive.
// - Status bit 0 flags preamble found during polling receive.
package rsw_pkg;
	localparam logic [7:0] ADDR_STATUS = 8'h13;
	localparam logic [7:0] ADDR_CONTROL = 8'h14;
	localparam logic [7:0] ADDR_STATE = 8'h15;
	localparam logic [7:0] ADDR_SETTLE = 8'h16;
	localparam logic [7:0] ADDR_LISTEN = 8'h17;
	localparam logic [7:0] ADDR_RATIO = 8'h18;
	localparam logic [7:0] ADDR_AFE = 8'h19;
	localparam logic [7:0] ADDR_TRIM = 8'h1A;
	localparam logic [7:0] ADDR_PART = 8'h1E;
	// Control bit positions
	localparam int CTL_OSC = 2;
	localparam int CTL_WUT = 1;
	localparam int CTL_RX = 0;
	// Front-end config field positions
	localparam int AFE_DLY_LSB = 6;
	localparam int AFE_DIV_LSB = 4;
	localparam int AFE_INJ = 3;
	localparam int AFE_LO_LSB = 1;
	localparam int AFE_FRAC = 0;
	// Reset values
	localparam logic [1:0] SETTLE_RST = 2'h3;
	localparam logic [7:0] LISTEN_RST = 8'h00;
	localparam logic [6:0] RATIO_RST = 7'h00;
	localparam logic [7:0] AFE_RST = 8'h93;
	localparam logic [4:0] TRIM_RST = 5'h00;
	// Timing: one step of the timer is 0.08 ms
	localparam int CLK_PERIOD_PS = 10000;
	localparam int STEP_NS = 80000;
	localparam int STEP_CYCLES = (STEP_NS * 1000) / CLK_PERIOD_PS;
	localparam logic [8:0] LISTEN_BASE_STEPS = 9'h006; // 0.48 ms
	localparam logic [7:0] DLY_16 = 8'h10;
	localparam logic [7:0] DLY_32 = 8'h20;
	localparam logic [7:0] DLY_64 = 8'h40;
	// State codes as read back
	localparam logic [1:0] RXS_STANDBY = 2'h0;
	localparam logic [1:0] RXS_DIRECT = 2'h1;
	localparam logic [1:0] RXS_WAIT = 2'h2;
	localparam logic [1:0] RXS_POLL = 2'h3;
	typedef enum logic [3:0] {
		ST_STANDBY = 4'b0001,
		ST_DIRECT = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_POLL = 4'b1000
	} rsw_state_e;
endpackage : rsw_pkg

// ===== rtl/rsw_xo_gate.sv
// Start delay and divider for the oscillator-derived digital clock.
// Assumes i_clk is the running oscillator clock; output is a tick enable.
`timescale 1ns/1ps
module rsw_xo_gate (
	input wire logic i_clk, // Oscillator clock
	input wire logic i_rst_b, // Async reset, active low
	input wire logic i_osc_en, // Oscillator enable
	input wire logic [1:0] i_delay_code, // Start delay select
	input wire logic [1:0] i_div_code, // Divider select
	output logic o_ready, // Digital clock is applied
	output logic o_dig_tick // One pulse per divided clock
);
	import rsw_pkg::*;

	typedef struct packed {
		logic [7:0] dly_cnt;
		logic ready;
		logic [2:0] div_cnt;
		logic tick;
	} rsw_gate_s;

	rsw_gate_s cur_ff;
	rsw_gate_s nxt_cur;
	logic [7:0] dly_target;
	logic [2:0] div_last;

	////////////////////////////////////////////////////////////////////////
	// Decode of delay and divide codes
	always_comb begin
		case (i_delay_code)
			2'h0: dly_target = 8'h00;
			2'h1: dly_target = DLY_16;
			2'h2: dly_target = DLY_32;
			default: dly_target = DLY_64;
		endcase
		// Invalid code 3 falls back to divide by 6 rather than run too fast
		case (i_div_code)
			2'h0: div_last = 3'h3;
			2'h1: div_last = 3'h4;
			default: div_last = 3'h5;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Delay counter restarts whenever the oscillator is switched off
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.tick = 1'b0;
		if (!i_osc_en) begin
			nxt_cur.dly_cnt = 8'h00;
			nxt_cur.ready = 1'b0;
			nxt_cur.div_cnt = 3'h0;
		end else if (!cur_ff.ready) begin
			if (cur_ff.dly_cnt >= dly_target) begin
				nxt_cur.ready = 1'b1;
			end else begin
				nxt_cur.dly_cnt = cur_ff.dly_cnt + 8'h01;
			end
		end else if (cur_ff.div_cnt >= div_last) begin
			nxt_cur.div_cnt = 3'h0;
			nxt_cur.tick = 1'b1;
		end else begin
			nxt_cur.div_cnt = cur_ff.div_cnt + 3'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign o_ready = cur_ff.ready;
	assign o_dig_tick = cur_ff.tick;
endmodule : rsw_xo_gate

// ===== testbench/rsw_top_chk.sv
// Port assertions for the receiver state and front-end config bank.
// Assumes it is bound to rsw_top and sees only that module's ports.
`timescale 1ns/1ps
module rsw_top_chk import rsw_pkg::*; #(
	parameter logic [7:0] PART_CODE = 8'h5A // Arbitrary designator value
) (
	input wire logic i_clk, // Clock
	input wire logic i_rst_b, // Async reset, active low
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	input wire logic [7:0] i_addr, // Address
	input wire logic [7:0] i_wdata, // Write data
	input wire logic [7:0] o_rdata, // Read data
	input wire logic o_front_end_on, // Front end settled
	input wire logic o_rx_active, // Receiver powered
	input wire logic [1:0] o_rx_state, // State code
	input wire logic o_osc_enable, // Oscillator enable
	input wire logic o_dig_ready, // Digital clock applied
	input wire logic o_lo_injection_side, // LO side
	input wire logic [1:0] o_lo_band_divider, // LO band
	input wire logic o_pll_fractional_select, // PLL mode
	input wire logic [4:0] o_image_rejection_trim // Trim
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	////////////////////////////////////////////////////////////////////////
	// Read data and field outputs follow the host's last access; receiver power follows the state code
	chk_state_readback: assert property (
		i_rd && i_addr == ADDR_STATE |=> o_rdata == {6'h00, $past(o_rx_state)})
		else $error("state readback differs from state code");
	chk_active_map: assert property (
		o_rx_active == (o_rx_state == RXS_DIRECT || o_rx_state == RXS_POLL))
		else $error("receiver power does not match state code");
	chk_trim_write: assert property (
		i_wr && i_addr == ADDR_TRIM |=>
		o_image_rejection_trim == $past(i_wdata[4:0]))
		else $error("trim output missed a write");
	chk_afe_fields: assert property (
		i_wr && i_addr == ADDR_AFE |=> {o_lo_injection_side,
		o_lo_band_divider, o_pll_fractional_select} == $past(i_wdata[3:0]))
		else $error("LO fields missed a write");
	chk_part_gated: assert property (
		i_rd && i_addr == ADDR_PART |=>
		o_rdata == ($past(o_osc_enable) ? PART_CODE : 8'h00))
		else $error("designator read wrong");
	chk_osc_write: assert property (
		i_wr && i_addr == ADDR_CONTROL |=> o_osc_enable == $past(i_wdata[2]))
		else $error("oscillator enable missed a write");
	// Everything dependent on the oscillator falls away once it stops
	chk_ready_drop: assert property (
		!o_osc_enable [*2] |-> !o_dig_ready)
		else $error("digital clock still applied with oscillator off");
	chk_standby_off: assert property (
		!o_osc_enable [*2] |-> o_rx_state == RXS_STANDBY)
		else $error("not in standby with oscillator off");
	chk_front_end_drop: assert property (
		!o_rx_active [*2] |-> !o_front_end_on)
		else $error("front end on outside receive states");
	cov_direct: cover property (o_rx_state == RXS_DIRECT);
	cov_poll: cover property (o_rx_state == RXS_POLL && o_front_end_on);
	cov_part: cover property (i_rd && i_addr == ADDR_PART && o_osc_enable);
endmodule : rsw_top_chk

// ===== testbench/rsw_host.sv
// Host controller model issuing register strobes to the bank.
// Assumes strobes are taken on the rising edge, read answer one cycle later.
`timescale 1ns/1ps
module rsw_host import rsw_pkg::*; (
	input wire logic i_clk, // Clock
	input wire logic [7:0] i_rdata, // Read data
	input wire logic i_rvalid, // Read valid
	output logic o_wr, // Write strobe
	output logic o_rd, // Read strobe
	output logic [7:0] o_addr, // Address
	output logic [7:0] o_wdata // Write data
);
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////
	// Released lines show inverted data so stale values never look valid
	task automatic idle();
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = ~o_addr;
		o_wdata = ~o_wdata;
	endtask : idle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		#1 o_wr = 1'b1;
		o_addr = a;
		o_wdata = (a == ADDR_AFE) ? (d | 8'h01) : d;
		@(posedge i_clk);
		#1 idle();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		@(posedge i_clk);
		#1 o_rd = 1'b1;
		o_addr = a;
		@(posedge i_clk);
		#1 ok = (i_rvalid === 1'b1);
		d = i_rdata;
		idle();
	endtask : rd
endmodule : rsw_host

// ===== testbench/rsw_top_bench.sv
// Self-checking bench for the register bank and polling sequencer.
// Assumes a shortened timer step so the polling periods stay brief.
`timescale 1ns/1ps
module rsw_top_bench;
	import rsw_pkg::*;
	localparam int STEP = 4;
	localparam logic [7:0] PART = 8'hC3; // Arbitrary designator value
	localparam logic [15:0] RST_TAB [9] = '{16'h1603, 16'h1700, 16'h1800,
		16'h1993, 16'h1A00, 16'h1500, 16'h1300, 16'h1E00, 16'h2000};
	logic clk, rst_b, wr, rd, pre, rvalid, fe_on, ready, tick, ok;
	logic [7:0] addr, wdata, rdata, d, a, v, l;
	logic [6:0] r;
	logic [1:0] state, s;
	int fail_count = 0;
	int checks = 0;
	int n;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	rsw_host u_host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
		.o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
	rsw_top #(.STEP_CYC(STEP), .PART_CODE(PART)) u_dut (.i_clk(clk),
		.i_rst_b(rst_b), .i_wr(wr), .i_rd(rd), .i_addr(addr),
		.i_wdata(wdata), .i_preamble_found(pre), .o_rdata(rdata),
		.o_rvalid(rvalid), .o_front_end_on(fe_on), .o_rx_active(),
		.o_rx_state(state), .o_osc_enable(), .o_dig_ready(ready),
		.o_dig_tick(tick), .o_lo_injection_side(), .o_lo_band_divider(),
		.o_pll_fractional_select(), .o_image_rejection_trim());
	////////////////////////////////////////////////////////////////////////
	// Checking helpers
	task automatic end_sim();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] ra, input logic [7:0] exp);
		u_host.rd(ra, d, ok);
		chk({7'h00, ok, d}, {8'h01, exp});
	endtask : rchk
	// Every register except control must show its reset value, at start and after a reset
	task automatic chk_reset_vals();
		foreach (RST_TAB[i]) begin
			rchk(RST_TAB[i][15:8], RST_TAB[i][7:0]);
		end
	endtask : chk_reset_vals
	// Sel 0 ready, 1 front end, 2 tick, 4..7 state code plus four
	task automatic wait_sig(input int sel, output int cyc);
		logic hit;
		cyc = 0;
		do begin
			@(posedge clk);
			#1 cyc++;
			hit = (sel == 0) ? ready : (sel == 1) ? fe_on :
				(sel == 2) ? tick : (state == 2'(sel - 4));
		end while (hit !== 1'b1 && cyc < 5000);
		chk(16'(hit), 16'h0001);
		if (hit !== 1'b1) end_sim();
	endtask : wait_sig
	// Writable bits per register; reserved bits must read back as zero
	function automatic logic [7:0] exp_rw(input logic [7:0] ea,
		input logic [7:0] ev);
		case (ea)
			ADDR_SETTLE: return ev & 8'h03;
			ADDR_RATIO: return ev & 8'h7F;
			ADDR_AFE: return ev | 8'h01;
			ADDR_TRIM: return ev & 8'h1F;
			default: return ev;
		endcase
	endfunction : exp_rw
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_b = 1'b0;
		pre = 1'b0;
		void'($urandom(58656));
		repeat (12) @(posedge clk);
		#1 rst_b = 1'b1;
		chk_reset_vals();
		repeat (24) begin
			a = ADDR_SETTLE + 8'($urandom_range(4));
			v = 8'($urandom);
			if (a == ADDR_AFE && v[5:4] == 2'h3) v[5] = 1'b0;
			u_host.wr(a, v);
			rchk(a, exp_rw(a, v));
		end
		u_host.wr(ADDR_STATE, 8'hFF);
		u_host.wr(ADDR_PART, 8'hFF);
		rchk(ADDR_STATE, 8'h00);
		rchk(ADDR_PART, 8'h00);
		// Start delay for each code, divider for codes 0 to 2
		for (int i = 0; i < 4; i++) begin
			u_host.wr(ADDR_CONTROL, 8'h00);
			u_host.wr(ADDR_AFE, {2'(i), 2'(i % 3), 4'h3});
			u_host.wr(ADDR_CONTROL, 8'h04);
			wait_sig(0, n);
			// Cycles beyond the selected start delay, a few allowed
			n -= (i == 0) ? 0 : (8 << i);
			chk(16'(n >= 0 && n <= 6), 16'h0001);
			wait_sig(2, n);
			wait_sig(2, n);
			chk(16'(n), 16'(4 + i % 3));
		end
		rchk(ADDR_PART, PART);
		// Direct receive with a random turn-on time
		s = 2'($urandom_range(3));
		u_host.wr(ADDR_SETTLE, {6'h00, s});
		u_host.wr(ADDR_CONTROL, 8'h05);
		wait_sig(5, n);
		wait_sig(1, n);
		chk(16'(n > s * STEP && n <= (s + 1) * STEP + 2), 16'h0001);
		rchk(ADDR_STATE, {6'h00, RXS_DIRECT});
		u_host.wr(ADDR_CONTROL, 8'h04);
		rchk(ADDR_STATE, {6'h00, RXS_STANDBY});
		// Self-polling: shortest, longest and random listen times
		for (int i = 0; i < 3; i++) begin
			l = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom_range(15));
			r = (i == 0) ? 7'h01 : (i == 1) ? 7'h00 : 7'($urandom_range(3));
			u_host.wr(ADDR_LISTEN, l);
			u_host.wr(ADDR_RATIO, {1'b0, r});
			u_host.wr(ADDR_CONTROL, 8'h06);
			wait_sig(7, n);
			wait_sig(6, n);
			chk(16'(n), 16'((6 + l) * STEP));
			wait_sig(7, n);
			chk(16'(n), 16'((1 + r) * (6 + l) * STEP));
			pre = 1'b1;
			@(posedge clk);
			#1 pre = 1'b0;
			rchk(ADDR_STATUS, 8'h01);
			rchk(ADDR_STATUS, 8'h00);
			// Last pass sets direct receive on top of polling
			u_host.wr(ADDR_CONTROL, (i == 2) ? 8'h07 : 8'h04);
		end
		// Poll drops to standby, then direct receive takes over
		wait_sig(5, n);
		chk(16'(n), 16'h0002);
		u_host.wr(ADDR_CONTROL, 8'h04);
		pre = 1'b1;
		@(posedge clk);
		#1 pre = 1'b0;
		rchk(ADDR_STATUS, 8'h00);
		// Mid-run reset must return every register except control to its reset value
		rst_b = 1'b0;
		repeat (3) @(posedge clk);
		#1 rst_b = 1'b1;
		chk({15'h0000, ready}, 16'h0000);
		chk_reset_vals();
		end_sim();
	end
endmodule : rsw_top_bench
bind rsw_top rsw_top_chk #(.PART_CODE(PART_CODE)) u_chk (.i_clk(i_clk),
	.i_rst_b(i_rst_b), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
	.i_wdata(i_wdata), .o_rdata(o_rdata), .o_front_end_on(o_front_end_on),
	.o_rx_active(o_rx_active), .o_rx_state(o_rx_state),
	.o_osc_enable(o_osc_enable), .o_dig_ready(o_dig_ready),
	.o_lo_injection_side(o_lo_injection_side),
	.o_lo_band_divider(o_lo_band_divider),
	.o_pll_fractional_select(o_pll_fractional_select),
	.o_image_rejection_trim(o_image_rejection_trim));
